//--- rtl/touch_target_pkg.sv
package touch_target_pkg;

  // geometry of the controller's internal byte space
  localparam int unsigned MEM_ADDR_W = 4;
  localparam int unsigned MEM_DEPTH  = 16;
  localparam int unsigned DATA_W     = 8;

  // fixed upper part of the 7-bit bus address, lower part comes from the config byte
  localparam logic [2:0] ADDR_UPPER     = 3'h3;
  localparam logic [3:0] CFG_INDEX      = 4'h0;
  localparam logic [7:0] CFG_RESET      = 8'h80;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] PTR_RESET      = 4'h0;

  // bus timing owed by the host, kept for reference by the bench
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned BUS_FREE_NS     = 4700;
  localparam int unsigned BUS_FREE_CYCLES = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_ADDR  = 6'b00_0010,
    ST_ACK   = 6'b00_0100,
    ST_WRITE = 6'b00_1000,
    ST_READ  = 6'b01_0000,
    ST_HACK  = 6'b10_0000
  } link_state_type;

  // one byte write into the internal byte space
  typedef struct packed {
    logic                  valid;
    logic [MEM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     data;
  } byte_write_type;

endpackage : touch_target_pkg

//--- rtl/touch_byte_memory.sv
`timescale 1ns/1ns
module touch_byte_memory (
  input  wire logic                                    clk_in,
  input  wire touch_target_pkg::byte_write_type        wr_in,
  input  wire logic [touch_target_pkg::MEM_ADDR_W-1:0] rd_addr_in,
  output logic      [touch_target_pkg::DATA_W-1:0]     rd_data_out
);

  logic [touch_target_pkg::DATA_W-1:0] mem [touch_target_pkg::MEM_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // contents are not reset: software is expected to load what it reads
  always_ff @(posedge clk_in)
  begin
    if (wr_in.valid)
    begin
      mem[wr_in.addr] <= wr_in.data;
    end
    rd_data_out <= mem[rd_addr_in]; // registered read, one cycle from address change
  end

endmodule : touch_byte_memory

//--- rtl/touch_panel_i2c_target.sv
`timescale 1ns/1ns
// Summary of operation
// - device is only a bus target, never starts a transfer itself.
// - address bits six to four are fixed at binary 011.
// - address bits three to zero follow config byte bits seven to four.
// - stop ends a packet; a repeated start ends it and opens the next.
// - device drives a dedicated line flagging touch data to the host.
module touch_panel_i2c_target (
  input  wire logic                                    clk_in,
  input  wire logic                                    rstn_in,
  input  wire logic                                    touch_reset_n_in,
  input  wire logic                                    scl_in,
  input  wire logic                                    sda_in,
  output logic                                         sda_out,
  output logic                                         sda_oe_out,
  input  wire touch_target_pkg::byte_write_type        touch_wr_in,
  output logic                                         touch_event_irq_out,
  output logic      [touch_target_pkg::DATA_W-1:0]     bus_control_cfg_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address match: fixed upper bits plus config-driven lower bits
  function automatic logic addr_hit(input logic [7:0] first_byte, input logic [7:0] cfg);
    addr_hit = (first_byte[7:5] == touch_target_pkg::ADDR_UPPER)
             && (first_byte[4:1] == cfg[7:4]);
  endfunction : addr_hit

  logic                                    rst_ok;
  logic                                    scl_q, sda_q;
  logic                                    scl_rise, scl_fall, start_cond, stop_cond;
  touch_target_pkg::link_state_type        state, next_state;
  logic [3:0]                              bitcnt, next_bitcnt;
  logic [7:0]                              shift, next_shift;
  logic                                    rw, next_rw;
  logic                                    first, next_first;
  logic [touch_target_pkg::MEM_ADDR_W-1:0] ptr, next_ptr;
  logic [7:0]                              cfg, next_cfg;
  logic                                    oe, next_oe;
  logic                                    irq, next_irq;
  logic                                    read_done, commit_wr;
  touch_target_pkg::byte_write_type        pend, next_pend, mem_wr;
  logic [7:0]                              mem_rd;

  // either reset pin holds every register except the byte memory in reset
  assign rst_ok = rstn_in && touch_reset_n_in;

  ////////////////////////////////////////////////////////////////////////////
  // bus condition detection from the previous sample of both lines
  assign scl_rise   = scl_in && !scl_q;
  assign scl_fall   = !scl_in && scl_q;
  assign start_cond = scl_in && scl_q && sda_q && !sda_in;
  assign stop_cond  = scl_in && scl_q && !sda_q && sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // touch writes own the memory port; a bus write waits until a cycle with no touch write
  always_comb
  begin
    mem_wr          = touch_wr_in.valid ? touch_wr_in : pend;
    next_pend       = pend;
    next_pend.valid = pend.valid && touch_wr_in.valid; // held only while a touch write blocks it
    if (commit_wr)
    begin
      next_pend = '{valid: 1'b1, addr: ptr, data: shift};
    end
  end

  touch_byte_memory u_mem (
    .clk_in      (clk_in),
    .wr_in       (mem_wr),
    .rd_addr_in  (ptr),
    .rd_data_out (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // target protocol engine; only ever reacts to host-made conditions
  always_comb
  begin
    next_state  = state;
    next_bitcnt = bitcnt;
    next_shift  = shift;
    next_rw     = rw;
    next_first  = first;
    next_ptr    = ptr;
    next_cfg    = cfg;
    next_oe     = oe;
    read_done   = 1'b0;
    case (state)
      touch_target_pkg::ST_IDLE:
      begin
        next_oe = 1'b0;
      end
      touch_target_pkg::ST_ADDR:
      begin
        if (scl_rise)
        begin
          next_shift  = {shift[6:0], sda_in};
          next_bitcnt = bitcnt + 4'h1;
        end
        else if (scl_fall && bitcnt == touch_target_pkg::BITS_PER_BYTE)
        begin
          if (addr_hit(shift, cfg))
          begin
            next_oe    = 1'b1;
            next_rw    = shift[0];
            next_first = 1'b1;
            next_state = touch_target_pkg::ST_ACK;
          end
          else
          begin
            next_state = touch_target_pkg::ST_IDLE;
          end
        end
      end
      touch_target_pkg::ST_ACK:
      begin
        if (scl_fall && rw)
        begin
          // first read bit goes out on the same fall that ends the ack
          next_oe     = !mem_rd[7];
          next_shift  = {mem_rd[6:0], 1'b0};
          next_bitcnt = 4'h1;
          next_state  = touch_target_pkg::ST_READ;
        end
        else if (scl_fall)
        begin
          next_oe     = 1'b0;
          next_bitcnt = 4'h0;
          next_state  = touch_target_pkg::ST_WRITE;
        end
      end
      touch_target_pkg::ST_WRITE:
      begin
        if (scl_rise)
        begin
          next_shift  = {shift[6:0], sda_in};
          next_bitcnt = bitcnt + 4'h1;
        end
        else if (scl_fall && bitcnt == touch_target_pkg::BITS_PER_BYTE)
        begin
          next_oe    = 1'b1;
          next_state = touch_target_pkg::ST_ACK;
          if (first)
          begin
            // first data byte after the address selects the byte pointer
            next_ptr   = shift[3:0];
            next_first = 1'b0;
          end
          else
          begin
            next_ptr = ptr + 4'h1;
            if (ptr == touch_target_pkg::CFG_INDEX)
            begin
              next_cfg = shift;
            end
          end
        end
      end
      touch_target_pkg::ST_READ:
      begin
        if (scl_fall && bitcnt == touch_target_pkg::BITS_PER_BYTE)
        begin
          next_oe    = 1'b0;
          read_done  = 1'b1;
          next_state = touch_target_pkg::ST_HACK;
        end
        else if (scl_fall)
        begin
          next_oe     = !shift[7];
          next_shift  = {shift[6:0], 1'b0};
          next_bitcnt = bitcnt + 4'h1;
        end
      end
      touch_target_pkg::ST_HACK:
      begin
        // a nack ends the read; an ack moves to the next byte
        if (scl_rise && sda_in)
        begin
          next_state = touch_target_pkg::ST_IDLE;
        end
        else if (scl_rise)
        begin
          next_ptr = ptr + 4'h1;
        end
        else if (scl_fall)
        begin
          next_oe     = !mem_rd[7];
          next_shift  = {mem_rd[6:0], 1'b0};
          next_bitcnt = 4'h1;
          next_state  = touch_target_pkg::ST_READ;
        end
      end
      default:
      begin
        next_oe    = 1'b0;
        next_state = touch_target_pkg::ST_IDLE;
      end
    endcase
    // bus conditions override whatever byte was in flight
    if (stop_cond)
    begin
      next_oe    = 1'b0;
      next_state = touch_target_pkg::ST_IDLE;
    end
    if (start_cond)
    begin
      next_oe     = 1'b0;
      next_bitcnt = 4'h0;
      next_state  = touch_target_pkg::ST_ADDR;
    end
  end

  // host line rises on every touch update and falls once a read byte is done
  always_comb
  begin
    next_irq = touch_wr_in.valid || (irq && !read_done); // set beats the read clear
  end

  // data byte completes while the ack is being driven; hand it to the memory
  assign commit_wr = (state == touch_target_pkg::ST_WRITE) && scl_fall && !first
                   && (bitcnt == touch_target_pkg::BITS_PER_BYTE) && !start_cond && !stop_cond;

  ////////////////////////////////////////////////////////////////////////////
  // state registers and the previous samples of both lines (idle high)
  always_ff @(posedge clk_in)
  begin
    if (!rst_ok)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      state  <= touch_target_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shift  <= 8'h00;
      rw     <= 1'b0;
      first  <= 1'b0;
      ptr    <= touch_target_pkg::PTR_RESET;
      cfg    <= touch_target_pkg::CFG_RESET;
      oe     <= 1'b0;
      irq    <= 1'b0;
      pend   <= '0;
    end
    else
    begin
      scl_q  <= scl_in;
      sda_q  <= sda_in;
      state  <= next_state;
      bitcnt <= next_bitcnt;
      shift  <= next_shift;
      rw     <= next_rw;
      first  <= next_first;
      ptr    <= next_ptr;
      cfg    <= next_cfg;
      oe     <= next_oe;
      irq    <= next_irq;
      pend   <= next_pend;
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_out             = 1'b0;
  assign sda_oe_out          = oe;
  assign touch_event_irq_out = irq;
  assign bus_control_cfg_out = cfg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_ok);

  sequence addr_byte_done;
    state == touch_target_pkg::ST_ADDR && scl_fall && bitcnt == 4'h8 && !start_cond && !stop_cond;
  endsequence

  a_idle_never_drives: assert property (state == touch_target_pkg::ST_IDLE |-> !sda_oe_out)
    else $error("target drives sda while idle");
  a_addr_hit_acks: assert property (addr_byte_done ##0 (shift[7:5] == 3'h3)
    ##0 (shift[4:1] == cfg[7:4]) |=> state == touch_target_pkg::ST_ACK && sda_oe_out)
    else $error("matching address not acknowledged");
  a_addr_miss_quiet: assert property (addr_byte_done ##0 (shift[4:1] != cfg[7:4])
    |=> state == touch_target_pkg::ST_IDLE && !sda_oe_out)
    else $error("foreign address acknowledged");
  a_restart_reopens: assert property (start_cond
    |=> state == touch_target_pkg::ST_ADDR && bitcnt == 4'h0 && !sda_oe_out)
    else $error("start did not open a new packet");
  a_stop_closes: assert property (stop_cond && !start_cond
    |=> state == touch_target_pkg::ST_IDLE ##1 !sda_oe_out)
    else $error("stop did not close the packet");
  a_irq_on_touch: assert property (touch_wr_in.valid |=> touch_event_irq_out)
    else $error("touch update did not raise the host line");
  a_irq_holds: assert property (touch_event_irq_out && !read_done |=> touch_event_irq_out)
    else $error("host line dropped without a read");

endmodule : touch_panel_i2c_target

//--- tb/i2c_host_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// host bus controller model: drives scl, releases sda onto a pulled-up wire
module i2c_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // quarter bit of 13 clocks gives a 2.6 us bit, just under 400 kHz
  localparam int QUARTER = 13;

  // idle bus: both lines released high, scl stands still
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic wait_q;
    repeat (QUARTER) @(posedge clk_in);
  endtask : wait_q

  // also a repeated start: sda is raised while scl is still low
  task automatic start;
    sda_out <= 1'b1;
    wait_q();
    scl_out <= 1'b1;
    wait_q();
    sda_out <= 1'b0;
    wait_q();
    scl_out <= 1'b0;
    wait_q();
  endtask : start

  // one bit, sampled in the middle of the scl high phase
  task automatic bit_io(input logic tx, output logic rx);
    sda_out <= tx;
    wait_q();
    scl_out <= 1'b1;
    wait_q();
    rx = sda_in;
    wait_q();
    scl_out <= 1'b0;
    wait_q();
  endtask : bit_io

  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_tx, ack_rx);
  endtask : xfer

  // stop, then hold the bus free before any new start
  task automatic stop;
    sda_out <= 1'b0;
    wait_q();
    scl_out <= 1'b1;
    wait_q();
    sda_out <= 1'b1;
    repeat (touch_target_pkg::BUS_FREE_CYCLES) @(posedge clk_in);
  endtask : stop
endmodule : i2c_host_model

//--- tb/test_touch_panel_i2c_target.sv
`timescale 1ns/1ns
module test_touch_panel_i2c_target;
  logic                             clk_in           = 1'b0;
  logic                             rstn_in          = 1'b0;
  logic                             touch_reset_n_in = 1'b1;
  touch_target_pkg::byte_write_type touch_wr         = '0;
  logic                             scl;
  logic                             host_sda;
  logic                             sda_wire;
  logic                             dut_sda;
  logic                             dut_oe;
  logic                             irq;
  logic [7:0]                       cfg;
  int                               err_total        = 0;
  int                               checks_done      = 0;

  always #25 clk_in = ~clk_in;

  // open-drain wire with pull-up: low when either party pulls it
  assign sda_wire = host_sda & ~(dut_oe & ~dut_sda);

  i2c_host_model i2c_host_model_inst (
    .clk_in (clk_in),
    .sda_in (sda_wire),
    .scl_out(scl),
    .sda_out(host_sda)
  );

  touch_panel_i2c_target touch_panel_i2c_target_inst (
    .clk_in             (clk_in),
    .rstn_in            (rstn_in),
    .touch_reset_n_in   (touch_reset_n_in),
    .scl_in             (scl),
    .sda_in             (sda_wire),
    .sda_out            (dut_sda),
    .sda_oe_out         (dut_oe),
    .touch_wr_in        (touch_wr),
    .touch_event_irq_out(irq),
    .bus_control_cfg_out(cfg)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // one byte from the host; ack slot released and compared with exp_ack
  task automatic send(input logic [7:0] tx, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    i2c_host_model_inst.xfer(tx, 1'b1, rx, ack);
    check("ack", {7'h00, ack}, {7'h00, exp_ack});
  endtask : send

  task automatic wrap_up;
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////////////////
  // outputs after reset, before any bus traffic
  task automatic test_reset;
    check("cfg", cfg, touch_target_pkg::CFG_RESET);
    check("irq", {7'h00, irq}, 8'h00);
    check("oe", {7'h00, dut_oe}, 8'h00);
  endtask : test_reset

  // address 0x38 answers; rewriting config moves it to 0x35; wrong top bits ignored
  task automatic test_address;
    i2c_host_model_inst.start();
    send(8'h70, 1'b0);
    send(8'h00, 1'b0);
    send(8'h50, 1'b0);
    i2c_host_model_inst.stop();
    check("cfg", cfg, 8'h50);
    check("idle oe", {7'h00, dut_oe}, 8'h00);
    i2c_host_model_inst.start();
    send(8'h70, 1'b1);
    i2c_host_model_inst.stop();
    i2c_host_model_inst.start();
    send(8'h8A, 1'b1);
    i2c_host_model_inst.stop();
    i2c_host_model_inst.start();
    send(8'h6A, 1'b0);
    i2c_host_model_inst.stop();
  endtask : test_address

  // touch reset input puts config back to its reset value
  task automatic test_touch_reset;
    touch_reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    touch_reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check("cfg", cfg, touch_target_pkg::CFG_RESET);
  endtask : test_touch_reset

  // touch write raises irq; pointer write, repeated start, read clears irq
  task automatic test_read_irq;
    logic [7:0] rx;
    logic       ack;
    touch_wr <= '{valid: 1'b1, addr: 4'h3, data: 8'hA5};
    @(posedge clk_in);
    touch_wr <= '0;
    repeat (2) @(posedge clk_in);
    check("irq", {7'h00, irq}, 8'h01);
    i2c_host_model_inst.start();
    send(8'h70, 1'b0);
    send(8'h03, 1'b0);
    i2c_host_model_inst.start();
    send(8'h71, 1'b0);
    i2c_host_model_inst.xfer(8'hFF, 1'b1, rx, ack);
    check("read data", rx, 8'hA5);
    i2c_host_model_inst.stop();
    check("irq", {7'h00, irq}, 8'h00);
    check("idle oe", {7'h00, dut_oe}, 8'h00);
  endtask : test_read_irq

  // two bytes stored from pointer 4, read back with a host ack stepping the pointer
  task automatic test_burst;
    logic [7:0] rx;
    logic       ack;
    i2c_host_model_inst.start();
    send(8'h70, 1'b0);
    send(8'h04, 1'b0);
    send(8'h3C, 1'b0);
    send(8'hC3, 1'b0);
    i2c_host_model_inst.stop();
    i2c_host_model_inst.start();
    send(8'h70, 1'b0);
    send(8'h04, 1'b0);
    i2c_host_model_inst.start();
    send(8'h71, 1'b0);
    i2c_host_model_inst.xfer(8'hFF, 1'b0, rx, ack);
    check("burst byte 0", rx, 8'h3C);
    i2c_host_model_inst.xfer(8'hFF, 1'b1, rx, ack);
    check("burst byte 1", rx, 8'hC3);
    i2c_host_model_inst.stop();
    check("cfg", cfg, touch_target_pkg::CFG_RESET);
    check("idle oe", {7'h00, dut_oe}, 8'h00);
  endtask : test_burst

  //////////////////////////////////////////////////////////////////////////////
  // reset by the host, then the scenarios in order
  initial
  begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    test_reset();
    test_address();
    test_touch_reset();
    test_read_irq();
    test_burst();
    wrap_up();
  end

  // watchdog: the scenarios need about 10200 cycles
  initial
  begin
    repeat (40000) @(posedge clk_in);
    err_total++;
    wrap_up();
  end
endmodule : test_touch_panel_i2c_target
